// ===== inc/blink_if.sv
interface blink_if;
  logic [1:0] mode;
  logic       run;
  logic       en;
  logic       seg;

  modport ctrl    (output mode, output run, output en, input seg);
  modport blinker (input mode, input run, input en, output seg);
endinterface

// ===== inc/lcd_cmd_defs.svh
`ifndef LCD_CMD_DEFS_SVH
`define LCD_CMD_DEFS_SVH

// command byte codes and prefixes
`define CMD_SCAN_HI     4'hC
`define CMD_PWR_HI      5'h05
`define CMD_RATIO_HI    5'h04
`define CMD_CONTRAST    8'h81
`define CMD_IND_OFF     8'hAC
`define CMD_IND_ON      8'hAD
`define CMD_ALL_OFF     8'hA4
`define CMD_ALL_ON      8'hA5
`define CMD_DISP_OFF    8'hAE
`define CMD_DISP_ON     8'hAF
`define CMD_RMW         8'hE0
`define CMD_RMW_END     8'hEE
`define CMD_RESET       8'hE2

// field positions inside the command byte
`define SCAN_DIR_POS    3
`define CONTRAST_MSB    5
`define IND_MSB         1
`define IND_OFF_CODE    2'h0
`define IND_STEADY_CODE 2'h3
`define IND_SLOW_CODE   2'h1

// reset values of the settings
`define RST_DIR         1'b0
`define RST_PWR         3'h0
`define RST_RATIO       3'h0
`define RST_CONTRAST    6'h20
`define RST_IND         2'h0

// timing
`define CLK_HZ          40000000
`define BLINK_SLOW_MS   1000
`define BLINK_FAST_MS   500
`define BLINK_SLOW_CYC  (`BLINK_SLOW_MS * (`CLK_HZ / 1000))
`define BLINK_FAST_CYC  (`BLINK_FAST_MS * (`CLK_HZ / 1000))
`define BLINK_CNT_W     26

`endif

// ===== inc/lcd_cmd_pkg.sv
`include "lcd_cmd_defs.svh"

package lcd_cmd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b001,
    ST_CONTRAST  = 3'b010,
    ST_INDICATOR = 3'b100
  } dec_state_e;

  typedef enum logic [2:0] {
    PM_NORMAL  = 3'b001,
    PM_STANDBY = 3'b010,
    PM_SLEEP   = 3'b100
  } power_mode_e;

  typedef struct packed {
    dec_state_e  st;
    power_mode_e pm;
    logic        wr_n_prev;
    logic        dir;
    logic [2:0]  pwr;
    logic [2:0]  ratio;
    logic [5:0]  contrast;
    logic [1:0]  ind;
    logic        rmw;
    logic        disp_on;
    logic        all_on;
    logic        foll_en;
    logic        reg_en;
    logic        boost_en;
    logic        osc_run;
    logic        ground;
    logic        ram_en;
  } dec_state_s;

  typedef struct packed {
    logic [`BLINK_CNT_W-1:0] cnt;
    logic                    phase;
    logic                    seg;
  } blink_state_s;

endpackage

// ===== rtl/bit_sync.sv
module bit_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             clk_en_in,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output wire logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_s;

  sync_state_s q;
  sync_state_s d;

  // meta is read only by the second stage
  always_comb begin
    d      = q;
    d.meta = async_in;
    d.sync = q.meta;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '{meta: RESET_VALUE, sync: RESET_VALUE};
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  assign sync_out = q.sync;
endmodule

// ===== rtl/indicator_blink.sv
`include "lcd_cmd_defs.svh"

module indicator_blink #(
  parameter int SLOW_CYCLES = `BLINK_SLOW_CYC,
  parameter int FAST_CYCLES = `BLINK_FAST_CYC
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // control and drive
  blink_if.blinker  bl
);
  import lcd_cmd_pkg::*;

  localparam logic [`BLINK_CNT_W-1:0] SLOW_LIM =
    `BLINK_CNT_W'(SLOW_CYCLES - 1);
  localparam logic [`BLINK_CNT_W-1:0] FAST_LIM =
    `BLINK_CNT_W'(FAST_CYCLES - 1);

  blink_state_s q;
  blink_state_s d;
  logic [`BLINK_CNT_W-1:0] lim;

  always_comb begin
    d   = q;
    lim = (bl.mode == `IND_SLOW_CODE) ? SLOW_LIM : FAST_LIM;
    // stopped oscillator: counter and phase hold
    if (bl.run) begin
      if (bl.mode[0] ^ bl.mode[1]) begin
        if (q.cnt >= lim) begin
          d.cnt   = '0;
          d.phase = ~q.phase;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end else begin
        d.cnt   = '0;
        d.phase = 1'b1;
      end
      d.seg = (bl.mode == `IND_STEADY_CODE) ||
              ((bl.mode[0] ^ bl.mode[1]) && d.phase);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '{cnt: '0, phase: 1'b1, seg: 1'b0};
    end else if (bl.en) begin
      q <= d;
    end
  end

  assign bl.seg = q.seg;
endmodule

// ===== rtl/lcd_power_contrast_command_decoder.sv
`include "lcd_cmd_defs.svh"

module lcd_power_contrast_command_decoder #(
  parameter int SLOW_CYCLES = `BLINK_SLOW_CYC,
  parameter int FAST_CYCLES = `BLINK_FAST_CYC
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       clk_en_in,
  // host command pins
  input  wire logic       cmd_write_n_in,
  input  wire logic       cmd_data_sel_in,
  input  wire logic [7:0] cmd_byte_in,
  // settings
  output wire logic       scan_direction_bit_out,
  output wire logic [2:0] power_circuit_enables_out,
  output wire logic [2:0] regulator_resistor_ratio_out,
  output wire logic [5:0] contrast_level_out,
  output wire logic [1:0] indicator_blink_mode_out,
  output wire logic       rmw_mode_out,
  // power circuits and drivers
  output wire logic       follower_en_out,
  output wire logic       regulator_enable_bit_out,
  output wire logic       booster_enable_bit_out,
  output wire logic       osc_run_out,
  output wire logic       drivers_ground_out,
  output wire logic       ram_access_en_out,
  output wire logic       indicator_segment_out,
  // status
  output wire logic       sleep_out,
  output wire logic       standby_out
);
  import lcd_cmd_pkg::*;

  localparam dec_state_s RST_STATE = '{
    st: ST_IDLE, pm: PM_NORMAL, wr_n_prev: 1'b1,
    dir: `RST_DIR, pwr: `RST_PWR, ratio: `RST_RATIO,
    contrast: `RST_CONTRAST, ind: `RST_IND, rmw: 1'b0,
    disp_on: 1'b0, all_on: 1'b0, foll_en: 1'b0, reg_en: 1'b0,
    boost_en: 1'b0, osc_run: 1'b1, ground: 1'b0, ram_en: 1'b1};

  dec_state_s q;
  dec_state_s d;
  logic [9:0] sync_v;
  logic       s_wr_n;
  logic       s_sel;
  logic [7:0] s_byte;
  logic       take;

  blink_if bl ();

  // pins cross in: strobe, select and byte sampled together
  // reset to idle pin levels: no false strobe edge after reset
  bit_sync #(
    .WIDTH       (10),
    .RESET_VALUE (10'h300)
  ) u_sync (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .clk_en_in (clk_en_in),
    .async_in  ({cmd_write_n_in, cmd_data_sel_in, cmd_byte_in}),
    .sync_out  (sync_v)
  );

  assign s_wr_n = sync_v[9];
  assign s_sel  = sync_v[8];
  assign s_byte = sync_v[7:0];
  // byte taken on rising write strobe; data writes ignored
  assign take   = s_wr_n && !q.wr_n_prev && !s_sel;

  always_comb begin
    d           = q;
    d.wr_n_prev = s_wr_n;
    if (take) begin
      case (q.st)
        ST_CONTRAST: begin
          d.contrast = s_byte[`CONTRAST_MSB:0];
          d.st       = ST_IDLE;
        end
        ST_INDICATOR: begin
          d.ind = s_byte[`IND_MSB:0];
          d.st  = ST_IDLE;
        end
        ST_IDLE: begin
          if (s_byte[7:4] == `CMD_SCAN_HI) begin
            d.dir = s_byte[`SCAN_DIR_POS];
          end else if (s_byte[7:3] == `CMD_PWR_HI) begin
            d.pwr = s_byte[2:0];
          end else if (s_byte[7:3] == `CMD_RATIO_HI) begin
            d.ratio = s_byte[2:0];
          end else begin
            case (s_byte)
              `CMD_CONTRAST: begin
                d.st = ST_CONTRAST;
              end
              `CMD_IND_OFF: begin
                d.ind = `IND_OFF_CODE;
              end
              `CMD_IND_ON: begin
                d.st = ST_INDICATOR;
              end
              `CMD_RMW: begin
                d.rmw = 1'b1;
              end
              `CMD_RMW_END: begin
                d.rmw = 1'b0;
              end
              `CMD_DISP_OFF: begin
                d.disp_on = 1'b0;
              end
              `CMD_DISP_ON: begin
                d.disp_on = 1'b1;
                d.pm      = PM_NORMAL;
              end
              `CMD_ALL_OFF: begin
                d.all_on = 1'b0;
                d.pm     = PM_NORMAL;
              end
              `CMD_ALL_ON: begin
                d.all_on = 1'b1;
                if (!q.disp_on) begin
                  d.pm = (q.ind == `IND_OFF_CODE) ? PM_SLEEP
                                                  : PM_STANDBY;
                end
              end
              `CMD_RESET: begin
                // power enables survive: only the pin resets supplies
                d.dir      = `RST_DIR;
                d.ratio    = `RST_RATIO;
                d.contrast = `RST_CONTRAST;
                d.ind      = `RST_IND;
                d.rmw      = 1'b0;
                if (q.pm == PM_STANDBY) begin
                  d.pm = PM_SLEEP;
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end
    // supplies run only in normal mode
    d.foll_en  = d.pwr[0] && (d.pm == PM_NORMAL);
    d.reg_en   = d.pwr[1] && (d.pm == PM_NORMAL);
    d.boost_en = d.pwr[2] && (d.pm == PM_NORMAL);
    d.osc_run  = (d.pm != PM_SLEEP);
    d.ground   = (d.pm != PM_NORMAL);
    d.ram_en   = 1'b1;
  end

  // async reset drops any pending second byte
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q <= RST_STATE;
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  // blink keeps running in standby, stops with the oscillator
  assign bl.mode = q.ind;
  assign bl.run  = q.osc_run;
  assign bl.en   = clk_en_in;

  indicator_blink #(
    .SLOW_CYCLES (SLOW_CYCLES),
    .FAST_CYCLES (FAST_CYCLES)
  ) u_blink (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .bl       (bl.blinker)
  );

  assign scan_direction_bit_out       = q.dir;
  assign power_circuit_enables_out    = q.pwr;
  assign regulator_resistor_ratio_out = q.ratio;
  assign contrast_level_out           = q.contrast;
  assign indicator_blink_mode_out     = q.ind;
  assign rmw_mode_out                 = q.rmw;
  assign follower_en_out              = q.foll_en;
  assign regulator_enable_bit_out     = q.reg_en;
  assign booster_enable_bit_out       = q.boost_en;
  assign osc_run_out                  = q.osc_run;
  assign drivers_ground_out           = q.ground;
  assign ram_access_en_out            = q.ram_en;
  assign indicator_segment_out        = bl.seg;
  // one-hot mode: each status bit is a flop of its own
  assign sleep_out                    = q.pm[2];
  assign standby_out                  = q.pm[1];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  a_scan_dir_set: assert property (
    take && clk_en_in && q.st == ST_IDLE && s_byte[7:4] == `CMD_SCAN_HI
    |=> scan_direction_bit_out == $past(s_byte[`SCAN_DIR_POS]))
    else $error("scan direction not taken from bit 3");
  a_power_bits_set: assert property (
    take && clk_en_in && q.st == ST_IDLE && s_byte[7:3] == `CMD_PWR_HI
    |=> power_circuit_enables_out == $past(s_byte[2:0]))
    else $error("power control bits not stored");
  a_follower_gate: assert property (
    !standby_out && !sleep_out |-> follower_en_out ==
    power_circuit_enables_out[0] && booster_enable_bit_out ==
    power_circuit_enables_out[2])
    else $error("power enable does not follow its bit");
  a_ratio_set: assert property (
    take && clk_en_in && q.st == ST_IDLE && s_byte[7:3] == `CMD_RATIO_HI
    |=> regulator_resistor_ratio_out == $past(s_byte[2:0]))
    else $error("resistor ratio not stored");
  a_contrast_arm: assert property (
    take && clk_en_in && q.st == ST_IDLE && s_byte == `CMD_CONTRAST
    |=> q.st == ST_CONTRAST)
    else $error("contrast mode not entered");
  a_contrast_pair: assert property (
    take && clk_en_in && q.st == ST_CONTRAST
    |=> contrast_level_out == $past(s_byte[`CONTRAST_MSB:0])
        && q.st == ST_IDLE)
    else $error("contrast data byte mishandled");
  a_contrast_only: assert property (
    take && clk_en_in && q.st == ST_CONTRAST
    |=> $stable(scan_direction_bit_out) && $stable(sleep_out)
        && $stable(indicator_blink_mode_out))
    else $error("contrast data acted on as a command");
  a_indicator_arm: assert property (
    take && clk_en_in && q.st == ST_IDLE && s_byte == `CMD_IND_ON
    |=> q.st == ST_INDICATOR)
    else $error("indicator data mode not entered");
  a_indicator_set: assert property (
    take && clk_en_in && q.st == ST_INDICATOR
    |=> indicator_blink_mode_out == $past(s_byte[`IND_MSB:0])
        && q.st == ST_IDLE)
    else $error("indicator data byte mishandled");
  a_indicator_hold: assert property (
    !$past(take && clk_en_in) |-> $stable(indicator_blink_mode_out))
    else $error("indicator changed without a command");
  a_save_entry: assert property (
    take && clk_en_in && q.st == ST_IDLE && s_byte == `CMD_ALL_ON
    && !q.disp_on |=> (sleep_out == ($past(q.ind) == `IND_OFF_CODE))
    && (sleep_out || standby_out))
    else $error("power save entry wrong");
  a_sleep_drive: assert property (
    sleep_out |-> !osc_run_out && drivers_ground_out
    && !follower_en_out && !regulator_enable_bit_out)
    else $error("sleep does not stop circuits");
  a_standby_reset: assert property (
    standby_out && take && clk_en_in && q.st == ST_IDLE
    && s_byte == `CMD_RESET |=> sleep_out && contrast_level_out ==
    `RST_CONTRAST)
    else $error("reset in standby did not enter sleep");
  a_ram_access: assert property (
    ram_access_en_out)
    else $error("ram access lost");
  a_standby_drive: assert property (
    standby_out |-> osc_run_out && drivers_ground_out
    && !booster_enable_bit_out && !regulator_enable_bit_out)
    else $error("standby does not stop supplies");
  a_reset_cmd: assert property (
    take && clk_en_in && q.st == ST_IDLE && s_byte == `CMD_RESET
    |=> scan_direction_bit_out == `RST_DIR && !rmw_mode_out
    && indicator_blink_mode_out == `RST_IND
    && regulator_resistor_ratio_out == `RST_RATIO)
    else $error("reset command left a setting");
  a_save_exit: assert property (
    take && clk_en_in && q.st == ST_IDLE
    && (s_byte == `CMD_DISP_ON || s_byte == `CMD_ALL_OFF)
    |=> !sleep_out && !standby_out)
    else $error("power save not left");

  c_contrast_pair: cover property (
    q.st == ST_CONTRAST ##[1:20] q.st == ST_IDLE);
  c_standby: cover property (standby_out);
  c_sleep_exit: cover property (sleep_out ##[1:50] !sleep_out);
  c_blink_fall: cover property (
    indicator_blink_mode_out == 2'h1 && $fell(indicator_segment_out));
  c_scan_reverse: cover property ($rose(scan_direction_bit_out));
endmodule

// ===== test/host_model.sv
module host_model (
  // clock
  input  wire logic       clk_in,
  // command pins
  output logic            cmd_write_n_out,
  output logic            cmd_data_sel_out,
  output logic [7:0]      cmd_byte_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_write_n_out  = 1'b1;
    cmd_data_sel_out = 1'b1;
    cmd_byte_out     = 8'hA5;
  end

  // one byte a write; strobe low 3 cycles, high at least 3
  task automatic write_byte(input logic [7:0] b, input logic sel);
    @(negedge clk_in);
    cmd_byte_out     = b;
    cmd_data_sel_out = sel;
    cmd_write_n_out  = 1'b0;
    repeat (3) @(negedge clk_in);
    cmd_write_n_out = 1'b1;
    @(negedge clk_in);
    // hold time over: leave no stale byte on the pins
    cmd_byte_out     = ~b;
    cmd_data_sel_out = ~sel;
    repeat (2) @(negedge clk_in);
  endtask
endmodule

// ===== test/lcd_power_contrast_command_decoder_test.sv
module lcd_power_contrast_command_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_in = 1'b0;
  logic        reset_in;
  logic        clk_en_in;
  logic        wr_n, sel;
  logic [7:0]  cmd;
  logic        scan, osc, gnd, ram, seg, slp, stby, rmw, fol, regb, bst;
  logic [2:0]  pwr, ratio;
  logic [5:0]  con;
  logic [1:0]  ind;
  logic [31:0] seed = 32'hB873511F;
  int          errors, total_checks;
  int          m_dir, m_pwr, m_ratio, m_con, m_ind;
  int          m_rmw, m_pend, m_pm, m_disp;
  logic [7:0]  scan_cmds [4] = '{8'hC0, 8'hC8, 8'hC7, 8'hCF};

  always #12.5 clk_in = ~clk_in;

  host_model host (
    .clk_in           (clk_in),
    .cmd_write_n_out  (wr_n),
    .cmd_data_sel_out (sel),
    .cmd_byte_out     (cmd)
  );

  lcd_power_contrast_command_decoder #(
    .SLOW_CYCLES (8),
    .FAST_CYCLES (4)
  ) DUT (
    .clk_in                       (clk_in),
    .reset_in                     (reset_in),
    .clk_en_in                    (clk_en_in),
    .cmd_write_n_in               (wr_n),
    .cmd_data_sel_in              (sel),
    .cmd_byte_in                  (cmd),
    .scan_direction_bit_out       (scan),
    .power_circuit_enables_out    (pwr),
    .regulator_resistor_ratio_out (ratio),
    .contrast_level_out           (con),
    .indicator_blink_mode_out     (ind),
    .rmw_mode_out                 (rmw),
    .follower_en_out              (fol),
    .regulator_enable_bit_out     (regb),
    .booster_enable_bit_out       (bst),
    .osc_run_out                  (osc),
    .drivers_ground_out           (gnd),
    .ram_access_en_out            (ram),
    .indicator_segment_out        (seg),
    .sleep_out                    (slp),
    .standby_out                  (stby)
  );

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic mreset();
    m_dir = 0;
    m_pwr = 0;
    m_ratio = 0;
    m_con = 32;
    m_ind = 0;
    m_rmw = 0;
    m_pend = 0;
    m_pm = 0;
    m_disp = 0;
  endtask

  // pm: 0 normal, 1 standby, 2 sleep
  task automatic apply(input logic [7:0] b);
    if (m_pend == 1) m_con = b[5:0];
    else if (m_pend == 2) m_ind = b[1:0];
    else if (b[7:4] == 4'hC) m_dir = b[3];
    else if (b[7:3] == 5'h05) m_pwr = b[2:0];
    else if (b[7:3] == 5'h04) m_ratio = b[2:0];
    else if (b == 8'h81) m_pend = 3;
    else if (b == 8'hAD) m_pend = 4;
    else if (b == 8'hAC) m_ind = 0;
    else if (b == 8'hA5 && m_disp == 0) m_pm = (m_ind == 0) ? 2 : 1;
    else if (b == 8'hA4) m_pm = 0;
    else if (b == 8'hAF) begin
      m_pm = 0;
      m_disp = 1;
    end
    else if (b == 8'hAE) m_disp = 0;
    else if (b == 8'hE0) m_rmw = 1;
    else if (b == 8'hEE) m_rmw = 0;
    else if (b == 8'hE2) begin
      // power enables survive the command; only the pin clears them
      if (m_pm == 1) m_pm = 2;
      m_dir = 0;
      m_ratio = 0;
      m_con = 32;
      m_ind = 0;
      m_rmw = 0;
    end
    m_pend = (m_pend > 2) ? m_pend - 2 : 0;
  endtask

  task automatic check_all();
    logic [22:0] got, exp;
    got = {scan, pwr, ratio, con, ind, rmw, bst, regb, fol, osc, gnd, ram,
           slp, stby};
    exp = {1'(m_dir), 3'(m_pwr), 3'(m_ratio), 6'(m_con), 2'(m_ind),
           1'(m_rmw), 3'((m_pm == 0) ? m_pwr : 0), 1'(m_pm != 2),
           1'(m_pm != 0), 1'b1, 1'(m_pm == 2), 1'(m_pm == 1)};
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for the indicator drive level
  task automatic wait_seg(input logic v);
    int n;
    n = 0;
    while (seg !== v && n < 24) begin
      @(negedge clk_in);
      n++;
    end
    total_checks++;
    if (seg !== v) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, seg, v);
      finish_test();
    end
  endtask

  task automatic send(input logic [7:0] b, input logic s = 1'b0);
    host.write_byte(b, s);
    if (!s) apply(b);
    check_all();
  endtask

  task automatic end_test(input string n);
    $display("test %s done, mismatches so far %0d", n, errors);
  endtask

  initial begin
    reset_in = 1'b1;
    clk_en_in = 1'b1;
    mreset();
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    check_all();
    foreach (scan_cmds[i])
      send(scan_cmds[i]);
    for (int i = 0; i < 8; i++) send(8'h28 + 8'(i));
    for (int i = 0; i < 8; i++) send(8'h20 + 8'(i));
    end_test("settings");
    repeat (4) begin
      send(8'h81);
      send(rnd());
    end
    send(8'h81);
    send(8'hAD);
    send(8'hC8);
    repeat (2) send(rnd(), 1'b1);
    send(8'h81);
    send(8'h20);
    end_test("contrast");
    for (int i = 0; i < 4; i++) begin
      send(8'hAD);
      send(8'hFC | 8'(i));
      wait_seg(i != 0);
      if (i == 1 || i == 2) wait_seg(1'b0);
    end
    send(8'hC0);
    send(8'hAC);
    wait_seg(1'b0);
    end_test("indicator");
    send(8'hAF);
    send(8'hA5);
    send(8'hA4);
    send(8'hAE);
    send(8'h2F);
    send(8'hA5);
    send(8'hAF);
    send(8'hAE);
    send(8'hAD);
    send(8'h01);
    send(8'hA5);
    wait_seg(1'b1);
    wait_seg(1'b0);
    send(8'hE2);
    send(8'hA4);
    send(8'hE0);
    send(8'hEE);
    end_test("power save");
    clk_en_in = 1'b0;
    // a whole write inside the frozen time must be lost
    host.write_byte(8'hC8, 1'b0);
    repeat (4) @(negedge clk_in);
    check_all();
    clk_en_in = 1'b1;
    send(8'h81);
    reset_in = 1'b1;
    @(negedge clk_in);
    reset_in = 1'b0;
    mreset();
    check_all();
    send(8'hC8);
    end_test("reset");
    finish_test();
  end
endmodule
